// ### wpg_cls_if.sv
`timescale 1ns/1ps

// carries a function code to the classifier and its verdict back
interface wpg_cls_if;
	import wpg_pkg::*;
	logic [FUNC_W-1:0] code;
	logic              restricted;
	logic              offset_fn;

	modport asker (output code, input restricted, input offset_fn);
	modport judge (input code, output restricted, output offset_fn);
endinterface

// ### wpg_func_class.sv
`timescale 1ns/1ps

module wpg_func_class
(
	// classifier side of the carrier
	wpg_cls_if.judge cls
);
	import wpg_pkg::*;

	// ----------------------------------------------------------------
	// code decode
	// ----------------------------------------------------------------
	// read-only functions and the protect setting itself fall through
	assign cls.restricted = wpg_restricted(cls.code); // [R03]
	assign cls.offset_fn  = (cls.code == FN_OFFSET_MAN);

endmodule // wpg_func_class

// ### wpg_gate.sv
`timescale 1ns/1ps

// Operation
// R01 - while prohibited, refuse parameter edits, flash refusal, return to main menu
// R02 - while prohibited, read-only functions 000, 011, 012, 01E, 030 still run
// R03 - while prohibited, refuse 002-00F, 014, 01B, 020, 080, 200-207 with refusal
// R04 - protection setting takes only 0000 permitted (default) or 0001 prohibited
// R05 - a stored value becomes the active state only at next power-up
// R06 - registering any other value gives an error indication
// R07 - valid value registered: flash completion, then back to setting display
// R08 - the protect setting function stays reachable while prohibited
// R09 - manual current offset adjust only while setting holds the permitted code
// R10 - setting lives in nonvolatile storage, read before serving any request
module wpg_gate
(
	// clock and power-on reset
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	// operator request
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire wpg_pkg::wpg_req_e           req_kind,
	input  wire logic [wpg_pkg::FUNC_W-1:0]  req_code,
	input  wire logic [wpg_pkg::VAL_W-1:0]   req_value,
	// verdict pulses
	output logic                             grant,
	output logic                             refusal_indication,
	output logic                             return_main,
	output logic                             done_flash,
	output logic                             error_flash,
	output logic                             return_setting,
	// status
	output logic                             prohibit_active,
	output logic [wpg_pkg::VAL_W-1:0]        setting_stored,
	output logic                             setting_loaded,
	// nonvolatile storage
	output logic                             nv_rd_req,
	input  wire logic                        nv_rd_valid,
	input  wire logic [wpg_pkg::VAL_W-1:0]   nv_rd_data,
	output logic                             nv_wr_req,
	output logic [wpg_pkg::VAL_W-1:0]        nv_wr_data,
	input  wire logic                        nv_wr_done
);
	import wpg_pkg::*;

	typedef enum logic [1:0] {S_LOAD_REQ, S_LOAD_WAIT, S_IDLE, S_STORE_WAIT} wpg_state_e;

	// ----------------------------------------------------------------
	// state and next values
	// ----------------------------------------------------------------
	wpg_state_e         state_reg,    state_next;
	logic               active_reg,   active_next;
	logic [VAL_W-1:0]   stored_reg,   stored_next;
	logic [VAL_W-1:0]   wdata_reg,    wdata_next;
	logic               grant_reg,    grant_next;
	logic               refuse_reg,   refuse_next;
	logic               done_reg,     done_next;
	logic               error_reg,    error_next;
	logic               rd_req_reg,   rd_req_next;
	logic               wr_req_reg,   wr_req_next;

	// ----------------------------------------------------------------
	// function classifier
	// ----------------------------------------------------------------
	wpg_cls_if cls ();
	assign cls.code = req_code;
	wpg_func_class u_class
	(
		.cls (cls)
	);

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	// no request is served until the stored setting is loaded
	assign req_ready = (state_reg == S_IDLE);                                   // [R10]
	wire   req_take  = req_valid && req_ready;
	wire   val_ok    = (req_value == PROT_PERMIT) || (req_value == PROT_PROHIBIT); // [R04]
	wire   param_bad = (req_kind == WPG_REQ_PARAM) && active_reg;               // [R01]
	// unlisted codes, the read-only ones and the protect function are let through
	wire   util_bad  = (req_kind == WPG_REQ_UTIL)
		&& ((active_reg && cls.restricted)                                   // [R02] [R03] [R08]
		|| (cls.offset_fn && (stored_reg != PROT_PERMIT)));                  // [R09]
	wire   is_store  = (req_kind == WPG_REQ_STORE);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next  = state_reg;
		active_next = active_reg;
		stored_next = stored_reg;
		wdata_next  = wdata_reg;
		grant_next  = 1'b0;
		refuse_next = 1'b0;
		done_next   = 1'b0;
		error_next  = 1'b0;
		rd_req_next = 1'b0;
		wr_req_next = 1'b0;
		unique case (state_reg)
			S_LOAD_REQ:
			begin
				rd_req_next = 1'b1;                                             // [R10]
				state_next  = S_LOAD_WAIT;
			end
			S_LOAD_WAIT:
			begin
				if (nv_rd_valid)
				begin
					// apart from the reset clear, the only place the active state is ever written
					stored_next = nv_rd_data;                                   // [R05]
					active_next = (nv_rd_data == PROT_PROHIBIT);                // [R05]
					state_next  = S_IDLE;
				end
			end
			S_IDLE:
			begin
				if (req_take)
				begin
					if (is_store)
					begin
						if (val_ok)
						begin
							wr_req_next = 1'b1;
							wdata_next  = req_value;
							state_next  = S_STORE_WAIT;
						end
						else
						begin
							error_next = 1'b1;                                  // [R06]
						end
					end
					else if (param_bad || util_bad)
					begin
						refuse_next = 1'b1;                                     // [R01] [R03]
					end
					else
					begin
						grant_next = 1'b1;
					end
				end
			end
			S_STORE_WAIT:
			begin
				if (nv_wr_done)
				begin
					// active state untouched until the next power-up
					stored_next = wdata_reg;
					done_next   = 1'b1;                                         // [R07]
					state_next  = S_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg  <= S_LOAD_REQ;
			active_reg <= 1'b0;
			stored_reg <= PROT_RESET;
			wdata_reg  <= PROT_RESET;
			grant_reg  <= 1'b0;
			refuse_reg <= 1'b0;
			done_reg   <= 1'b0;
			error_reg  <= 1'b0;
			rd_req_reg <= 1'b0;
			wr_req_reg <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			active_reg <= active_next;
			stored_reg <= stored_next;
			wdata_reg  <= wdata_next;
			grant_reg  <= grant_next;
			refuse_reg <= refuse_next;
			done_reg   <= done_next;
			error_reg  <= error_next;
			rd_req_reg <= rd_req_next;
			wr_req_reg <= wr_req_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign grant              = grant_reg;
	assign refusal_indication = refuse_reg;
	assign return_main        = refuse_reg;    // refusal always drops to main menu
	assign done_flash         = done_reg;
	assign return_setting     = done_reg;      // back to the setting display
	assign error_flash        = error_reg;
	assign prohibit_active    = active_reg;
	assign setting_stored     = stored_reg;
	assign setting_loaded     = (state_reg == S_IDLE) || (state_reg == S_STORE_WAIT);
	assign nv_rd_req          = rd_req_reg;
	assign nv_wr_req          = wr_req_reg;
	assign nv_wr_data         = wdata_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	refuse_param_a: assert property (@(posedge ref_clk) disable iff (reset) // [R01]
		req_take && req_kind == WPG_REQ_PARAM && prohibit_active
		|=> refusal_indication && return_main && !grant)
		else $error("parameter edit not refused while prohibited");

	read_only_ok_a: assert property (@(posedge ref_clk) disable iff (reset) // [R02]
		req_take && req_kind == WPG_REQ_UTIL && (req_code == FN_ALARM_HIST
		|| req_code == 12'h011 || req_code == 12'h012 || req_code == 12'h01E
		|| req_code == 12'h030) |=> grant && !refusal_indication)
		else $error("read-only function refused");

	refuse_util_a: assert property (@(posedge ref_clk) disable iff (reset) // [R03]
		req_take && req_kind == WPG_REQ_UTIL && prohibit_active
		&& (req_code inside {[12'h002:12'h00F], 12'h014, 12'h01B, 12'h020,
		12'h080, [12'h200:12'h207]}) |=> refusal_indication && !grant)
		else $error("restricted function not refused");

	wr_code_valid_a: assert property (@(posedge ref_clk) disable iff (reset) // [R04]
		nv_wr_req |-> (nv_wr_data == PROT_PERMIT || nv_wr_data == PROT_PROHIBIT))
		else $error("invalid protection code written");

	active_stable_a: assert property (@(posedge ref_clk) disable iff (reset) // [R05]
		setting_loaded && $past(setting_loaded) |-> $stable(prohibit_active))
		else $error("active protection changed without power-up");

	bad_value_a: assert property (@(posedge ref_clk) disable iff (reset) // [R06]
		req_take && is_store && !val_ok |=> error_flash && !nv_wr_req ##1 req_ready)
		else $error("invalid protection value not flagged");

	store_req_a: assert property (@(posedge ref_clk) disable iff (reset) // [R07]
		req_take && is_store && val_ok |=> nv_wr_req && !done_flash && !req_ready)
		else $error("valid store did not start a write");

	// write latency is open ended, so the flash is tied to the done pulse itself
	done_seq_a: assert property (@(posedge ref_clk) disable iff (reset) // [R07]
		state_reg == S_STORE_WAIT && nv_wr_done |=> done_flash && return_setting
		&& setting_stored == $past(wdata_reg) && $stable(prohibit_active))
		else $error("completion not flashed after store");

	protect_fn_a: assert property (@(posedge ref_clk) disable iff (reset) // [R08]
		req_take && req_kind == WPG_REQ_UTIL && req_code == FN_PROTECT_SET |=> grant)
		else $error("protect setting function not reachable");

	offset_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // [R09]
		req_take && req_kind == WPG_REQ_UTIL && req_code == FN_OFFSET_MAN
		&& setting_stored != PROT_PERMIT |=> !grant && refusal_indication)
		else $error("offset adjust allowed without permitted code");

	load_first_a: assert property (@(posedge ref_clk) disable iff (reset) // [R10]
		$rose(setting_loaded) |-> $past(nv_rd_valid) && !$past(setting_loaded))
		else $error("requests served before setting loaded");

endmodule // wpg_gate

// ### wpg_nv_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// nonvolatile word store behind the gate
// ----------------------------------------------------------------
module wpg_nv_model
#(
	parameter logic [wpg_pkg::VAL_W-1:0] INIT = wpg_pkg::PROT_PERMIT
)
(
	// clock and answer latency in cycles
	input  wire logic                       ref_clk,
	input  wire logic [3:0]                 lat,
	// read side
	input  wire logic                       nv_rd_req,
	output logic                            nv_rd_valid,
	output logic [wpg_pkg::VAL_W-1:0]       nv_rd_data,
	// write side
	input  wire logic                       nv_wr_req,
	input  wire logic [wpg_pkg::VAL_W-1:0]  nv_wr_data,
	output logic                            nv_wr_done
);
	import wpg_pkg::*;

	// no reset input: the word outlives every power cycle
	logic [VAL_W-1:0] mem_reg = INIT;
	logic [VAL_W-1:0] wr_hold = '0;
	logic [3:0]       rd_cnt  = '0;
	logic [3:0]       wr_cnt  = '0;
	logic             rd_busy = 1'b0;
	logic             wr_busy = 1'b0;

	initial nv_rd_valid = 1'b0;
	initial nv_wr_done = 1'b0;

	// data is only good with valid; otherwise show the inverse so stale reads fail
	assign nv_rd_data = nv_rd_valid ? mem_reg : ~mem_reg;

	// each request answered after lat+1 idle cycles, one pulse, one at a time
	always @(posedge ref_clk)
	begin
		nv_rd_valid <= rd_busy && (rd_cnt == 4'h0);
		nv_wr_done  <= wr_busy && (wr_cnt == 4'h0);
		if (nv_rd_req)
		begin
			rd_busy <= 1'b1;
			rd_cnt  <= lat;
		end
		else if (rd_busy)
		begin
			rd_busy <= rd_cnt != 4'h0;
			rd_cnt  <= rd_cnt - 4'h1;
		end
		if (nv_wr_req)
		begin
			wr_busy <= 1'b1;
			wr_cnt  <= lat;
			wr_hold <= nv_wr_data;
		end
		else if (wr_busy)
		begin
			wr_busy <= wr_cnt != 4'h0;
			wr_cnt  <= wr_cnt - 4'h1;
			if (wr_cnt == 4'h0)
				mem_reg <= wr_hold;
		end
	end
endmodule // wpg_nv_model

// ### wpg_pkg.sv
package wpg_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int FUNC_W = 12;
	localparam int VAL_W  = 16;

	// ----------------------------------------------------------------
	// protection setting codes, permitted is also the factory value
	// ----------------------------------------------------------------
	localparam logic [VAL_W-1:0] PROT_PERMIT   = 16'h0000;
	localparam logic [VAL_W-1:0] PROT_PROHIBIT = 16'h0001;
	localparam logic [VAL_W-1:0] PROT_RESET    = PROT_PERMIT;

	// ----------------------------------------------------------------
	// utility function codes
	// ----------------------------------------------------------------
	localparam logic [FUNC_W-1:0] FN_ALARM_HIST   = 12'h000;
	localparam logic [FUNC_W-1:0] FN_RANGE_A_LO   = 12'h002;
	localparam logic [FUNC_W-1:0] FN_OFFSET_MAN   = 12'h00F;
	localparam logic [FUNC_W-1:0] FN_PROTECT_SET  = 12'h010;
	localparam logic [FUNC_W-1:0] FN_OPT_RESET    = 12'h014;
	localparam logic [FUNC_W-1:0] FN_VIB_INIT     = 12'h01B;
	localparam logic [FUNC_W-1:0] FN_ORIGIN_SET   = 12'h020;
	localparam logic [FUNC_W-1:0] FN_POLARITY     = 12'h080;
	localparam logic [FUNC_W-1:0] FN_RANGE_B_LO   = 12'h200;
	localparam logic [FUNC_W-1:0] FN_RANGE_B_HI   = 12'h207;

	// ----------------------------------------------------------------
	// operator request kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WPG_REQ_PARAM,
		WPG_REQ_UTIL,
		WPG_REQ_STORE
	} wpg_req_e;

	// true for functions that are refused while writes are prohibited
	function automatic logic wpg_restricted(input logic [FUNC_W-1:0] code);
		return ((code >= FN_RANGE_A_LO) && (code <= FN_OFFSET_MAN))
			|| (code == FN_OPT_RESET) || (code == FN_VIB_INIT)
			|| (code == FN_ORIGIN_SET) || (code == FN_POLARITY)
			|| ((code >= FN_RANGE_B_LO) && (code <= FN_RANGE_B_HI));
	endfunction

endpackage

// ### write_protect_gate_bench.sv
`timescale 1ns/1ps

module write_protect_gate_bench;
	import wpg_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic              ref_clk = 1'b0;
	logic              reset = 1'b1;
	logic              req_valid = 1'b0;
	wpg_req_e          req_kind = WPG_REQ_PARAM;
	logic [FUNC_W-1:0] req_code = '0;
	logic [VAL_W-1:0]  req_value = '0;
	logic              req_ready, grant, refusal_indication, return_main;
	logic              done_flash, error_flash, return_setting;
	logic              prohibit_active, setting_loaded, nv_rd_req, nv_rd_valid;
	logic              nv_wr_req, nv_wr_done;
	logic [VAL_W-1:0]  setting_stored, nv_rd_data, nv_wr_data;
	logic [3:0]        lat = 4'h2;
	int                n_errors = 0;
	int                comparisons = 0;

	wpg_gate u_dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_code(req_code),
		.req_value(req_value), .grant(grant), .refusal_indication(refusal_indication),
		.return_main(return_main), .done_flash(done_flash), .error_flash(error_flash),
		.return_setting(return_setting), .prohibit_active(prohibit_active),
		.setting_stored(setting_stored), .setting_loaded(setting_loaded),
		.nv_rd_req(nv_rd_req), .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
		.nv_wr_req(nv_wr_req), .nv_wr_data(nv_wr_data), .nv_wr_done(nv_wr_done));

	wpg_nv_model u_nv (.ref_clk(ref_clk), .lat(lat), .nv_rd_req(nv_rd_req),
		.nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .nv_wr_req(nv_wr_req),
		.nv_wr_data(nv_wr_data), .nv_wr_done(nv_wr_done));

	// 200 MHz clock
	initial forever #2.5 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("errors %0d of %0d comparisons", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// power cycle: the nv word is read back before any request is served
	task automatic power_up(input logic [15:0] nv_val);
		int n;
		n = 0;
		@(negedge ref_clk) reset = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(req_ready, 1'b0);
		reset = 1'b0;
		while (setting_loaded !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(setting_stored, nv_val);
		chk(prohibit_active, nv_val == PROT_PROHIBIT);
		chk(req_ready, 1'b1);
	endtask

	// one request; exp holds grant, refusal, error, nv write in that order
	task automatic req(input wpg_req_e k, input int c, input logic [15:0] v,
		input logic [3:0] exp);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1'b1;
		req_kind  = k;
		req_code  = 12'(c);
		req_value = v;
		// answer pulses stand for the cycle after the take edge only
		@(negedge ref_clk) req_valid = 1'b0;
		chk({grant, refusal_indication, error_flash, nv_wr_req}, exp);
		chk(return_main, exp[2]);
		@(negedge ref_clk);
	endtask

	// valid store: write goes out, completion flash, active state untouched
	task automatic store_ok(input logic [15:0] v, input logic prot);
		int n;
		n = 0;
		req(WPG_REQ_STORE, 0, v, 4'h1);
		chk(nv_wr_data, v);
		while (done_flash !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk({done_flash, return_setting}, 2'h3);
		chk(setting_stored, v);
		chk(prohibit_active, prot);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// factory word, bad codes rejected, prohibit stored but not yet active
	task automatic t_default;
		power_up(PROT_PERMIT);
		req(WPG_REQ_PARAM, 0, 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, 12'h00F, 16'h0000, 4'h8);
		req(WPG_REQ_STORE, 0, 16'h0005, 4'h2);
		req(WPG_REQ_STORE, 0, 16'h0002, 4'h2);
		req(WPG_REQ_STORE, 0, 16'hFFFF, 4'h2);
		store_ok(PROT_PROHIBIT, 1'b0);
		req(WPG_REQ_PARAM, 0, 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, 12'h203, 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, 12'h00F, 16'h0000, 4'h4);
	endtask

	// slow store read-back, then the full function table while prohibited
	task automatic t_prohibited;
		int lst[4] = '{12'h014, 12'h01B, 12'h020, 12'h080};
		int ro[5]  = '{12'h000, 12'h011, 12'h012, 12'h01E, 12'h030};
		lat = 4'h9;
		power_up(PROT_PROHIBIT);
		req(WPG_REQ_PARAM, 0, 16'h0000, 4'h4);
		req(WPG_REQ_PARAM, 0, 16'h1234, 4'h4);
		for (int c = 12'h002; c <= 12'h00F; c++)
			req(WPG_REQ_UTIL, c, 16'h0000, 4'h4);
		foreach (lst[i])
			req(WPG_REQ_UTIL, lst[i], 16'h0000, 4'h4);
		for (int c = 12'h200; c <= 12'h207; c++)
			req(WPG_REQ_UTIL, c, 16'h0000, 4'h4);
		foreach (ro[i])
			req(WPG_REQ_UTIL, ro[i], 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, FN_PROTECT_SET, 16'h0000, 4'h8);
		req(WPG_REQ_STORE, 0, 16'h0003, 4'h2);
		store_ok(PROT_PERMIT, 1'b1);
		req(WPG_REQ_PARAM, 0, 16'h0000, 4'h4);
	endtask

	// next power-up brings the permitted word back into force
	task automatic t_restore;
		lat = 4'h0;
		power_up(PROT_PERMIT);
		req(WPG_REQ_PARAM, 0, 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, 12'h005, 16'h0000, 4'h8);
		req(WPG_REQ_UTIL, 12'h00F, 16'h0000, 4'h8);
	endtask

	// main sequence
	initial
	begin
		t_default;
		t_prohibited;
		t_restore;
		finish_test;
	end

	// watchdog, far beyond the well under two hundred cycles the run needs
	initial
	begin
		#100000;
		n_errors++;
		finish_test;
	end
endmodule // write_protect_gate_bench
